// ===== hdl/eict_core.sv
// Purpose: Decodes a requested extended or address instruction, times its execution
// Assumes: Caller presents operands and flags with the request; memory is outside
// Notes: Execution occupies exactly the computed number of clock cycles
`timescale 1ns/1ns
`default_nettype none

module eict_core (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic reqValid,
    output logic reqReady,
    input wire eict_pkg::eict_op_t reqOp,
    input wire eict_pkg::eict_mode_t reqSrcMode,
    input wire eict_pkg::eict_mode_t reqDstMode,
    input wire eict_pkg::eict_width_t reqWidth,
    input wire logic [4:0] reqCount,
    input wire logic reqRepeat,
    input wire logic reqBaseSp,
    input wire logic [19:0] srcData,
    input wire logic [19:0] dstData,
    input wire logic [3:0] flagsIn,
    output logic busy,
    output logic done,
    output logic illegalOut,
    output logic [19:0] resultOut,
    output logic [3:0] flagsOut,
    output logic writeDst,
    output logic [5:0] cyclesOut,
    output logic [2:0] wordsOut
);
    import eict_pkg::*;

    eict_state_t cur_q;
    eict_state_t nxt_d;
    logic [9:0] timing;
    logic accept;
    logic [20:0] sum;
    logic [20:0] diff;

    function automatic logic isMem(input eict_mode_t m);
        return (m == MD_IDX) || (m == MD_SYM) || (m == MD_ABS);
    endfunction : isMem

    // Address instructions: {illegal, words, cycles}
    function automatic logic [9:0] addrTiming(input eict_op_t op, input eict_mode_t s,
                                              input eict_mode_t d);
        logic ill;
        logic [2:0] w;
        logic [5:0] c;
        ill = 1'b0;
        w = 3'h1;
        c = 6'h01;
        if (op != OP_WIDE_TRANSFER) begin
            ill = !((s == MD_REG || s == MD_IMM) && (d == MD_REG || d == MD_PC));
        end else begin
            ill = (s == MD_PC) || (d != MD_REG && d != MD_PC && !(s == MD_REG && isMem(d)))
                || (d == MD_REG && 1'b0);
        end
        case (s)
            MD_REG: begin
                c = (d == MD_REG) ? 6'h01 : (d == MD_PC) ? 6'h03 : 6'h04;
                w = isMem(d) ? 3'h2 : 3'h1;
            end
            MD_IND, MD_AINC: begin
                c = (d == MD_PC) ? 6'h05 : 6'h03;
                w = 3'h1;
            end
            MD_IMM: begin
                c = (d == MD_REG && op == OP_WIDE_TRANSFER) ? 6'h02 : 6'h03;
                w = 3'h2;
            end
            default: begin
                c = (d == MD_PC) ? 6'h06 : 6'h04;
                w = 3'h2;
            end
        endcase
        return {ill, w, c};
    endfunction : addrTiming

    // Single-operand extended instructions
    function automatic logic [9:0] fmt2Timing(input eict_op_t op, input eict_mode_t s,
                                              input logic wide, input logic [4:0] n,
                                              input logic sp);
        logic ill;
        logic [2:0] w;
        logic [5:0] c;
        ill = 1'b0;
        w = 3'h1;
        c = 6'h01;
        case (op)
            OP_MULTI_SHIFT_RIGHT_ARITH, OP_MULTI_ROTATE_RIGHT_CARRY,
            OP_MULTI_SHIFT_RIGHT_UNSIGNED, OP_MULTI_SHIFT_LEFT_ARITH: begin
                ill = (s != MD_REG) || (n == 5'h00) || (n > MULTI_SHIFT_MAX);
                c = {1'b0, n};
            end
            OP_STACK_STORE_MULTIPLE, OP_STACK_LOAD_MULTIPLE: begin
                ill = (s != MD_REG) || (n == 5'h00) || (n > MULTI_STACK_MAX);
                c = wide ? 6'h02 + {n, 1'b0} : 6'h02 + {1'b0, n};
            end
            OP_WIDE_SUBROUTINE_CALL: begin
                ill = (s == MD_PC);
                case (s)
                    MD_REG: c = 6'h05;
                    MD_IND, MD_AINC: c = 6'h06;
                    MD_IMM: c = 6'h05;
                    MD_IDX: c = sp ? 6'h06 : 6'h05;
                    default: c = 6'h07;
                endcase
                w = (s == MD_REG || s == MD_IND || s == MD_AINC) ? 3'h1 : 3'h2;
            end
            OP_EXT_SHIFT_RIGHT_ARITH, OP_EXT_ROTATE_RIGHT_CARRY: begin
                ill = (s == MD_IMM) || (s == MD_PC) || (s == MD_REG && n == 5'h00);
                case (s)
                    MD_REG: c = 6'h01 + {1'b0, n};
                    MD_IND, MD_AINC: c = wide ? 6'h06 : 6'h04;
                    default: c = wide ? 6'h07 : 6'h05;
                endcase
                w = isMem(s) ? 3'h3 : 3'h2;
            end
            OP_EXT_STACK_STORE: begin
                ill = (s == MD_PC);
                case (s)
                    MD_REG, MD_IMM: c = wide ? 6'h05 : 6'h04;
                    MD_IND, MD_AINC: c = wide ? 6'h06 : 6'h04;
                    MD_IDX: c = (wide ? 6'h07 : 6'h05) + (sp ? 6'h01 : 6'h00);
                    default: c = wide ? 6'h07 : 6'h05;
                endcase
                w = (isMem(s) || s == MD_IMM) ? 3'h3 : 3'h2;
            end
            OP_EXT_STACK_LOAD: begin
                ill = !(s == MD_REG || isMem(s));
                c = (s == MD_REG) ? (wide ? 6'h04 : 6'h03) : (wide ? 6'h07 : 6'h05);
                w = (s == MD_REG) ? 3'h2 : 3'h3;
            end
            default: begin
                ill = 1'b1;
            end
        endcase
        return {ill, w, c};
    endfunction : fmt2Timing

    // Double-operand extended instructions; operation only trims the base figure
    function automatic logic [9:0] fmt1Timing(input eict_op_t op, input eict_mode_t s,
                                              input eict_mode_t d, input logic wide,
                                              input logic [4:0] n, input logic rpt);
        logic ill;
        logic [2:0] w;
        logic [5:0] c;
        logic memDst;
        logic pcDst;
        ill = (s == MD_PC) || (d == MD_IND) || (d == MD_AINC) || (d == MD_IMM);
        memDst = isMem(d);
        pcDst = (d == MD_PC);
        case (s)
            MD_REG: begin
                c = pcDst ? 6'h04 : memDst ? (wide ? 6'h07 : 6'h05) : 6'h02;
                w = 3'h2;
            end
            MD_IND, MD_AINC: begin
                c = pcDst ? (wide ? 6'h06 : 6'h05) : memDst ? (wide ? 6'h09 : 6'h06)
                    : (wide ? 6'h04 : 6'h03);
                w = 3'h2;
            end
            MD_IMM: begin
                c = pcDst ? 6'h04 : memDst ? (wide ? 6'h08 : 6'h06) : 6'h03;
                w = 3'h3;
            end
            default: begin
                c = pcDst ? (wide ? 6'h07 : 6'h06) : memDst ? (wide ? 6'h0a : 6'h07)
                    : (wide ? 6'h05 : 6'h04);
                w = 3'h3;
            end
        endcase
        if (memDst) begin
            w = w + 3'h1;
        end
        if (memDst && (op == OP_TRANSFER || op == OP_BIT_TEST || op == OP_COMPARE)) begin
            c = c - (wide ? 6'h02 : 6'h01);
        end
        if (pcDst && s != MD_REG && (op == OP_TRANSFER || op == OP_ADD || op == OP_SUBTRACT))
        begin
            c = c - 6'h01;
        end
        if (rpt && s == MD_REG && d == MD_REG && n != 5'h00) begin
            c = 6'h01 + {1'b0, n};
        end
        return {ill, w, c};
    endfunction : fmt1Timing

    always_comb begin
        if (reqOp <= OP_WIDE_TRANSFER) begin
            timing = addrTiming(reqOp, reqSrcMode, reqDstMode);
        end else if (reqOp <= OP_EXT_STACK_LOAD) begin
            timing = fmt2Timing(reqOp, reqSrcMode, reqWidth == WD_ADDR, reqCount, reqBaseSp);
        end else begin
            timing = fmt1Timing(reqOp, reqSrcMode, reqDstMode, reqWidth == WD_ADDR, reqCount,
                                reqRepeat);
        end
    end

    assign sum = {1'b0, dstData} + {1'b0, srcData};
    assign diff = {1'b0, dstData} + {1'b0, ~srcData} + 21'h00_0001;
    assign reqReady = (cur_q.fsm == ST_IDLE) && cur_q.enable;
    assign accept = reqValid && reqReady;

    always_comb begin
        nxt_d = cur_q;
        if (regWr && regAddr == ADDR_CTRL) begin
            nxt_d.enable = regWrData[CTRL_ENABLE_BIT];
        end
        nxt_d.rdData = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                ADDR_CTRL: nxt_d.rdData[CTRL_ENABLE_BIT] = cur_q.enable;
                ADDR_STATUS: begin
                    nxt_d.rdData[STAT_CYCLES_LSB +: 6] = cur_q.cycles;
                    nxt_d.rdData[STAT_WORDS_LSB +: 3] = cur_q.words;
                    nxt_d.rdData[STAT_ILLEGAL_BIT] = cur_q.illegal;
                    nxt_d.rdData[STAT_BUSY_BIT] = (cur_q.fsm == ST_EXEC);
                end
                ADDR_DONE_COUNT: nxt_d.rdData[15:0] = cur_q.doneCount;
                default: nxt_d.rdData = 32'h0000_0000;
            endcase
        end
        case (cur_q.fsm)
            ST_IDLE: begin
                if (accept) begin
                    nxt_d.fsm = ST_EXEC;
                    nxt_d.illegal = timing[9];
                    nxt_d.words = timing[8:6];
                    nxt_d.cycles = timing[9] ? 6'h01 : timing[5:0];
                    nxt_d.cnt = timing[9] ? 6'h01 : timing[5:0];
                    nxt_d.flags = flagsIn;
                    nxt_d.writeDst = 1'b0;
                    nxt_d.result = dstData;
                    if (!timing[9] && reqOp <= OP_WIDE_TRANSFER) begin
                        case (reqOp)
                            OP_REGISTER_PLUS: begin
                                nxt_d.result = sum[19:0];
                                nxt_d.flags[FLAG_C] = sum[20];
                                nxt_d.flags[FLAG_V] = (dstData[19] == srcData[19])
                                    && (sum[19] != dstData[19]);
                                nxt_d.writeDst = 1'b1;
                            end
                            OP_REGISTER_MINUS, OP_REGISTER_COMPARE: begin
                                nxt_d.result = diff[19:0];
                                nxt_d.flags[FLAG_C] = diff[20];
                                nxt_d.flags[FLAG_V] = (dstData[19] != srcData[19])
                                    && (diff[19] != dstData[19]);
                                nxt_d.writeDst = (reqOp == OP_REGISTER_MINUS);
                            end
                            default: begin
                                nxt_d.result = srcData;
                                nxt_d.writeDst = 1'b1;
                            end
                        endcase
                        if (reqOp != OP_WIDE_TRANSFER) begin
                            nxt_d.flags[FLAG_N] = nxt_d.result[19];
                            nxt_d.flags[FLAG_Z] = (nxt_d.result == 20'h0_0000);
                        end
                    end
                end
            end
            ST_EXEC: begin
                nxt_d.cnt = cur_q.cnt - 6'h01;
                if (cur_q.cnt == 6'h01) begin
                    nxt_d.fsm = ST_IDLE;
                    nxt_d.doneCount = cur_q.doneCount + 16'h0001;
                end
            end
            default: nxt_d.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur_q <= '0;
            cur_q.enable <= CTRL_ENABLE_RESET;
            cur_q.doneCount <= DONE_COUNT_RESET;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign busy = (cur_q.fsm == ST_EXEC);
    assign done = (cur_q.fsm == ST_EXEC) && (cur_q.cnt == 6'h01);
    assign regRdData = cur_q.rdData;
    assign illegalOut = cur_q.illegal;
    assign resultOut = cur_q.result;
    assign flagsOut = cur_q.flags;
    assign writeDst = cur_q.writeDst;
    assign cyclesOut = cur_q.cycles;
    assign wordsOut = cur_q.words;

    // Helper: clocks spent in execution so far
    logic [5:0] execSeen_q;
    always_ff @(posedge clk) begin
        if (!rst_b || !busy) begin
            execSeen_q <= 6'h00;
        end else begin
            execSeen_q <= execSeen_q + 6'h01;
        end
    end

    sequence sTake(eict_op_t op);
        accept && reqOp == op && !timing[9];
    endsequence

    sequence sTakeMode(eict_op_t op, eict_mode_t s);
        sTake(op) ##0 reqSrcMode == s;
    endsequence

    AST_EXEC_LENGTH: assert property (@(posedge clk) disable iff (!rst_b)
        done |-> execSeen_q + 6'h01 == cyclesOut)
        else $error("execution length differs from cycle count");
    AST_ADDR_MODES: assert property (@(posedge clk) disable iff (!rst_b)
        accept && reqOp == OP_REGISTER_PLUS && reqSrcMode == MD_IND |=> illegalOut && done)
        else $error("address add accepted an indirect source");
    AST_ADDR_ONE_WORD: assert property (@(posedge clk) disable iff (!rst_b)
        accept && reqOp <= OP_WIDE_TRANSFER && reqSrcMode == MD_REG && reqDstMode == MD_REG
        |=> wordsOut == 3'h1 && cyclesOut == 6'h01 ##1 !busy)
        else $error("register address instruction not one word and one cycle");
    AST_ADD_FLAGS: assert property (@(posedge clk) disable iff (!rst_b)
        sTake(OP_REGISTER_PLUS) |=> flagsOut[FLAG_Z] == (resultOut == 20'h0_0000)
        && flagsOut[FLAG_N] == resultOut[19] && writeDst)
        else $error("address add flags do not follow the result");
    AST_MOVE_FLAGS: assert property (@(posedge clk) disable iff (!rst_b)
        sTake(OP_WIDE_TRANSFER) |=> flagsOut == $past(flagsIn) && resultOut == $past(srcData))
        else $error("wide move changed flags or data");
    AST_COMPARE_KEEPS: assert property (@(posedge clk) disable iff (!rst_b)
        sTake(OP_REGISTER_COMPARE) |=> !writeDst throughout (busy [*1]))
        else $error("address compare requested a register write");
    AST_MULTI_SHIFT: assert property (@(posedge clk) disable iff (!rst_b)
        sTake(OP_MULTI_SHIFT_LEFT_ARITH) |=> cyclesOut == {1'b0, $past(reqCount)}
        && wordsOut == 3'h1)
        else $error("multi shift cycle count is not n");
    AST_STACK_MULTI_WIDE: assert property (@(posedge clk) disable iff (!rst_b)
        sTake(OP_STACK_STORE_MULTIPLE) ##0 reqWidth == WD_ADDR
        |=> cyclesOut == 6'h02 + {$past(reqCount), 1'b0})
        else $error("wide push multiple not 2+2n cycles");
    AST_CALL_SP_INDEX: assert property (@(posedge clk) disable iff (!rst_b)
        sTakeMode(OP_WIDE_SUBROUTINE_CALL, MD_IDX) ##0 reqBaseSp |=> cyclesOut == 6'h06
        ##5 done)
        else $error("stack based indexed call not six cycles");
    AST_REPEAT: assert property (@(posedge clk) disable iff (!rst_b)
        sTakeMode(OP_ADD, MD_REG) ##0 reqDstMode == MD_REG && reqRepeat && reqCount != 5'h00
        |=> cyclesOut == 6'h01 + {1'b0, $past(reqCount)})
        else $error("repeat count not n plus one");
    AST_MEM_MOVE_TRIM: assert property (@(posedge clk) disable iff (!rst_b)
        sTakeMode(OP_TRANSFER, MD_REG) ##0 reqDstMode == MD_ABS && reqWidth == WD_ADDR
        |=> cyclesOut == 6'h05)
        else $error("wide move to memory not trimmed by two");

endmodule : eict_core
`default_nettype wire

// ===== hdl/eict_pkg.sv
// Purpose: Shared types and constants for the extended instruction timing core
// Assumes: One 100 MHz clock; cycle figures are counted in that clock
// Notes: Opcode values are this core's own request codes, not instruction bits
package eict_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // Register port map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DONE_COUNT = 8'h08;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam logic [15:0] DONE_COUNT_RESET = 16'h0000;

    // Status register fields
    localparam int STAT_CYCLES_LSB = 0;
    localparam int STAT_WORDS_LSB = 8;
    localparam int STAT_ILLEGAL_BIT = 12;
    localparam int STAT_BUSY_BIT = 13;

    // Flag vector bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;

    // Operation counts that bound the count field
    localparam logic [4:0] MULTI_SHIFT_MAX = 5'h04;
    localparam logic [4:0] MULTI_STACK_MAX = 5'h10;

    typedef enum logic [4:0] {
        OP_REGISTER_PLUS = 5'h00,
        OP_REGISTER_MINUS = 5'h01,
        OP_REGISTER_COMPARE = 5'h02,
        OP_WIDE_TRANSFER = 5'h03,
        OP_MULTI_SHIFT_RIGHT_ARITH = 5'h04,
        OP_MULTI_ROTATE_RIGHT_CARRY = 5'h05,
        OP_MULTI_SHIFT_RIGHT_UNSIGNED = 5'h06,
        OP_MULTI_SHIFT_LEFT_ARITH = 5'h07,
        OP_STACK_STORE_MULTIPLE = 5'h08,
        OP_STACK_LOAD_MULTIPLE = 5'h09,
        OP_WIDE_SUBROUTINE_CALL = 5'h0a,
        OP_EXT_SHIFT_RIGHT_ARITH = 5'h0b,
        OP_EXT_ROTATE_RIGHT_CARRY = 5'h0c,
        OP_EXT_STACK_STORE = 5'h0d,
        OP_EXT_STACK_LOAD = 5'h0e,
        OP_TRANSFER = 5'h0f,
        OP_BIT_TEST = 5'h10,
        OP_COMPARE = 5'h11,
        OP_ADD = 5'h12,
        OP_SUBTRACT = 5'h13,
        OP_OTHER = 5'h14
    } eict_op_t;

    typedef enum logic [2:0] {
        MD_REG = 3'h0,
        MD_IND = 3'h1,
        MD_AINC = 3'h2,
        MD_IMM = 3'h3,
        MD_IDX = 3'h4,
        MD_SYM = 3'h5,
        MD_ABS = 3'h6,
        MD_PC = 3'h7
    } eict_mode_t;

    typedef enum logic [1:0] {
        WD_BYTE = 2'h0,
        WD_WORD = 2'h1,
        WD_ADDR = 2'h2
    } eict_width_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } eict_fsm_t;

    typedef struct packed {
        eict_fsm_t fsm;
        logic [5:0] cnt;
        logic [19:0] result;
        logic [3:0] flags;
        logic writeDst;
        logic illegal;
        logic [2:0] words;
        logic [5:0] cycles;
        logic enable;
        logic [15:0] doneCount;
        logic [31:0] rdData;
    } eict_state_t;

endpackage : eict_pkg

// ===== verification/eict_bus_model.sv
// Purpose: Far-side operand bus; raises a request and holds operands until taken
// Assumes: The core samples operands only at the accepting edge
// Notes: Released operands show their inverse so a late read is caught
`timescale 1ns/1ns
`default_nettype none
module eict_bus_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic reqReady,
    input wire logic [43:0] opnd,
    output logic reqValid,
    output logic [43:0] bus
);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reqValid <= 1'b0;
            bus <= 44'h000_0000_0000;
        end else if (go) begin
            reqValid <= 1'b1;
            bus <= opnd;
        end else if (reqValid && reqReady) begin
            reqValid <= 1'b0;
            bus <= ~bus;
        end
    end
endmodule : eict_bus_model
`default_nettype wire

// ===== verification/extended_instr_cycle_timing_tb.sv
// Purpose: Self-checking bench for the instruction timing core
// Assumes: Requests come through the bus model; registers over the plain port
// Notes: Cycle counts are table driven; address ops also check result and flags
`timescale 1ns/1ns
`default_nettype none
module extended_instr_cycle_timing_tb;
    import eict_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic go = 1'b0;
    logic [43:0] opnd = 44'h000_0000_0000;
    eict_op_t op = OP_OTHER;
    eict_mode_t sm = MD_REG;
    eict_mode_t dm = MD_REG;
    eict_width_t wd = WD_WORD;
    logic [4:0] cnt = 5'h00;
    logic rpt = 1'b0;
    logic sp = 1'b0;
    logic [31:0] regRdData;
    logic reqReady, reqValid, busy, done, illegalOut, writeDst;
    logic [43:0] bus;
    logic [19:0] resultOut;
    logic [3:0] flagsOut;
    logic [5:0] cyclesOut;
    logic [2:0] wordsOut;
    int n_mismatch = 0;
    int cmp_count = 0;
    int nDone = 0;
    int cs[51][9] = '{
        '{8,0,0,1,16,0,0,18,1}, '{9,0,0,2,3,0,0,8,1}, '{8,0,0,2,1,0,0,4,1},
        '{9,0,0,1,1,0,0,3,1}, '{10,0,0,2,0,0,0,5,1}, '{10,1,1,2,0,0,0,6,1},
        '{10,3,3,2,0,0,0,5,2}, '{10,4,4,2,0,0,0,5,2}, '{10,5,5,2,0,0,0,7,2},
        '{10,6,6,2,0,0,0,7,2}, '{10,4,4,2,0,0,1,6,2}, '{13,4,4,1,0,0,1,6,3},
        '{11,0,0,1,2,0,0,3,2}, '{12,1,1,0,1,0,0,4,2}, '{11,2,2,2,1,0,0,6,2},
        '{12,6,6,2,1,0,0,7,3}, '{13,0,0,1,0,0,0,4,2}, '{13,3,3,1,0,0,0,4,3},
        '{13,4,4,1,0,0,0,5,3}, '{13,1,1,2,0,0,0,6,2}, '{13,5,5,2,0,0,0,7,3},
        '{14,0,0,0,0,0,0,3,2}, '{14,5,5,1,0,0,0,5,3}, '{14,0,0,2,0,0,0,4,2},
        '{14,6,6,2,0,0,0,7,3}, '{18,0,0,1,0,0,0,2,2}, '{20,0,0,1,0,0,0,2,2},
        '{18,0,7,1,0,0,0,4,2}, '{20,0,6,2,0,0,0,7,3}, '{18,1,0,1,0,0,0,3,2},
        '{20,2,7,2,0,0,0,6,2}, '{18,1,6,1,0,0,0,6,3}, '{20,2,4,2,0,0,0,9,3},
        '{18,3,0,1,0,0,0,3,3}, '{20,3,7,1,0,0,0,4,3}, '{20,3,5,2,0,0,0,8,4},
        '{18,4,0,1,0,0,0,4,3}, '{20,5,0,2,0,0,0,5,3}, '{20,6,7,1,0,0,0,6,3},
        '{18,4,4,2,0,0,0,10,4}, '{15,0,5,1,0,0,0,4,3}, '{17,3,6,0,0,0,0,5,4},
        '{16,6,6,1,0,0,0,6,4}, '{17,0,4,2,0,0,0,5,3}, '{15,4,4,2,0,0,0,8,4},
        '{19,3,7,1,0,0,0,3,3}, '{18,4,7,2,0,0,0,6,3}, '{15,5,7,1,0,0,0,5,3},
        '{15,0,6,2,0,0,0,5,3},
        '{18,0,0,1,5,1,0,6,2}, '{19,0,0,2,1,1,0,2,2}};
    always #5 clk = ~clk;
    eict_core dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .reqValid(reqValid),
        .reqReady(reqReady), .reqOp(op), .reqSrcMode(sm), .reqDstMode(dm), .reqWidth(wd),
        .reqCount(cnt), .reqRepeat(rpt), .reqBaseSp(sp), .srcData(bus[43:24]),
        .dstData(bus[23:4]), .flagsIn(bus[3:0]), .busy(busy), .done(done),
        .illegalOut(illegalOut), .resultOut(resultOut), .flagsOut(flagsOut),
        .writeDst(writeDst), .cyclesOut(cyclesOut), .wordsOut(wordsOut));
    eict_bus_model bus_u (.clk(clk), .rst_b(rst_b), .go(go), .reqReady(reqReady),
        .opnd(opnd), .reqValid(reqValid), .bus(bus));
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        chk(regRdData, e);
    endtask : rd
    // Issue one request, count cycles from acceptance to the done cycle
    task automatic x(input int o, s, d, w, k, r, b, c, n);
        int m;
        @(posedge clk);
        op <= eict_op_t'(o[4:0]);
        sm <= eict_mode_t'(s[2:0]);
        dm <= eict_mode_t'(d[2:0]);
        wd <= eict_width_t'(w[1:0]);
        cnt <= k[4:0];
        rpt <= r[0];
        sp <= b[0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        m = 0;
        while (!(reqValid === 1'b1 && reqReady === 1'b1) && m < 20) begin
            @(posedge clk);
            m++;
        end
        m = 0;
        do begin
            @(posedge clk);
            m++;
        end while (done !== 1'b1 && m < 40);
        chk(m, c);
        chk(cyclesOut, c);
        if (n >= 0) chk(wordsOut, n);
        nDone++;
        if (m >= 40) give_verdict();
    endtask : x
    // Address op: e holds illegal, register write, flags and result
    task automatic a(input int o, s, c, n, input logic [43:0] v, input logic [25:0] e);
        opnd <= v;
        x(o, s, 0, 2, 0, 0, 0, c, n);
        chk(illegalOut, e[25]);
        chk(writeDst, e[24]);
        chk(flagsOut, e[23:20]);
        if (e[24]) chk(resultOut, e[19:0]);
    endtask : a
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_CTRL, 32'h0000_0001);
        rd(ADDR_DONE_COUNT, {16'h0000, DONE_COUNT_RESET});
        rd(8'h0c, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0000);
        @(posedge clk);
        chk(reqReady, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0001);
        a(0, 0, 1, 1, 44'h000_01FF_FFF0, 26'h130_0000);
        a(0, 3, 3, 2, 44'h400_0040_0000, 26'h1C8_0000);
        a(1, 0, 1, 1, 44'h000_0500_005F, 26'h130_0000);
        a(2, 0, 1, 1, 44'h000_0200_0010, 26'h040_0000);
        a(3, 1, 3, 1, 44'hABC_DE00_000A, 26'h1AA_BCDE);
        a(0, 1, 1, -1, 44'h000_0000_0005, 26'h250_0000);
        for (int i = 4; i < 8; i++) begin
            x(i, 0, 0, 1, i - 3, 0, 0, i - 3, 1);
        end
        for (int i = 0; i < 51; i++) begin
            x(cs[i][0], cs[i][1], cs[i][2], cs[i][3], cs[i][4], cs[i][5], cs[i][6],
                cs[i][7], cs[i][8]);
        end
        rd(ADDR_STATUS, 32'h0000_0202);
        rd(ADDR_DONE_COUNT, nDone);
        give_verdict();
    end
endmodule : extended_instr_cycle_timing_tb
`default_nettype wire
